// [common/fpx_map.svh]
/*
 * Register offsets, bit positions, tag codes, reset values and
 * bus answers of the invalid and subnormal exception unit.
 * Assumes inclusion by bare name from the package and the bench.
 */
`ifndef FPX_MAP_SVH
`define FPX_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FPX_OFF_CTRL       4'h0
`define FPX_OFF_STATUS     4'h4
`define FPX_OFF_MAINFLAGS  4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPX_BIT_INVALID    0
`define FPX_BIT_SUBNORMAL  1
`define FPX_BIT_SFKIND     6
`define FPX_BIT_SUMMARY    7
`define FPX_BIT_CND0       8
`define FPX_BIT_CND1       9
`define FPX_BIT_CND2       10
`define FPX_BIT_CND3       14
`define FPX_FLAG_W         6

// ----------------------------------------------------------------
// Register tags and reset values
// ----------------------------------------------------------------
`define FPX_TAG_VALID      2'h0
`define FPX_TAG_ZERO       2'h1
`define FPX_TAG_SPECIAL    2'h2
`define FPX_TAG_EMPTY      2'h3
`define FPX_CTRL_RST       2'h3
`define FPX_NAN_UNORDERED  3'h7
`define FPX_HRESP_OKAY     1'h0

`endif

// [common/fpx_pkg.sv]
/*
 * Types of the invalid and subnormal exception unit: operation
 * classes, operand classes and the request and answer carriers.
 * Assumes fpx_map.svh sits on the include path.
 */
package fpx_pkg;
	`include "fpx_map.svh"

	typedef enum logic [4:0] {
		OP_OTHER, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_PREM, OP_COS, OP_SIN,
		OP_SINCOS, OP_TAN, OP_SQRT, OP_YL2X, OP_YL2XP1, OP_BCD_STORE_POP,
		OP_INT_STORE, OP_ORD_CMP, OP_CMP_FLAGS, OP_UNORD_CMP, OP_LOAD_MEM,
		OP_STORE_MEM, OP_XCH
	} fpx_op_e;

	typedef enum logic [2:0] {
		CLS_NORMAL, CLS_ZERO, CLS_INF, CLS_SNAN, CLS_QNAN, CLS_DENORM, CLS_UNSUP
	} fpx_cls_e;

	typedef enum logic [1:0] {FMT_SINGLE, FMT_DOUBLE, FMT_EXT, FMT_INT} fpx_fmt_e;

	typedef enum logic [2:0] {
		SUB_NONE, SUB_QNAN_INDEF, SUB_QUIET_SRC, SUB_INT_INDEF, SUB_BCD_INDEF,
		SUB_NEG_ZERO, SUB_NEG_INF
	} fpx_subst_e;

	typedef struct packed {
		logic     valid;
		fpx_op_e  op;
		logic     a_used;
		logic     b_used;
		logic [1:0] a_tag;
		logic [1:0] b_tag;
		logic [1:0] dst_tag;
		fpx_cls_e a_cls;
		fpx_cls_e b_cls;
		logic     a_sign;
		logic     b_sign;
		fpx_fmt_e load_fmt;
		logic     fits_range;
		logic     below_minus_one;
	} fpx_req_s;

	typedef struct packed {
		logic       valid;
		logic       commit;
		logic       stack_fault;
		logic       invalid;
		logic       subnormal;
		fpx_subst_e subst;
		logic       fill_a;
		logic       fill_b;
		logic       normalize;
		logic       cc_we;
		logic [3:0] cc_mask;
		logic [3:0] cc_val;
		logic       mf_we;
		logic [2:0] mf_val;
	} fpx_resp_s;
endpackage

// [src/fpx_exc_unit.sv]
/*
 * Invalid-operation and subnormal-operand exception unit: classifies
 * each operation from the datapath, keeps control and status words
 * behind an AHB-Lite slave and answers with the masked response or a
 * handler request one cycle later.
 * Assumes the datapath presents one request per cycle at most and
 * that the sequencer holds off results while handler_req is high.
 */
// Our own choices: the AHB-Lite register port and the register addresses.
// Operation
// - Invalid flag is status bit 0; its mask is control bit 0.
// - Stack-fault-kind flag set on stack faults, never cleared by operand faults.
// - Overflow: memory load into a register whose tag is not empty.
// - Underflow: an empty-tagged register used as a source, stores included. Code excludes exchange, raising it as a plain invalid operand.
// - Any stack fault sets the invalid flag and the stack-fault-kind flag.
// - Stack fault writes condition bit one: 1 overflow, 0 underflow.
// - Masked stack fault writes the indefinite form the instruction needs.
// - Unmasked invalid requests the handler; stack pointer and sources kept.
// - Invalid operand sets the invalid flag; masked gives the default answer.
// - Quiet NaNs alone raise nothing except on ordered compares.
// - Masked: unsupported format gives indefinite; signalling NaN gives quiet NaN. Code gives indefinite if add/sub/mul/div has an inf or zero first operand.
// - Masked NaN compare sets condition bits 0,2,3 or main flags to 111B.
// - Masked infinity and zero conflicts give the quiet-NaN indefinite.
// - Masked remainder or trig faults give indefinite and clear condition bit two.
// - Masked square root, log2, log2-plus-one of bad operands give indefinite.
// - Masked BCD store of an out-of-range value stores BCD indefinite.
// - Masked integer store out of range stores integer indefinite.
// - Masked exchange fills empty registers with indefinite, then exchanges.
// - Subnormal raised on arithmetic use or single/double load, not extended.
// - Subnormal flag is status bit 1; its mask is control bit 1.
// - Masked subnormal sets its flag, continues and normalizes the load.
// - Unmasked subnormal sets its flag and requests the handler.
// - Summary bit shows that at least one exception flag is set.
`timescale 1ns/1ps
module fpx_exc_unit
	import fpx_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Datapath request and answer
	input  wire fpx_req_s    req,
	output fpx_resp_s        resp,
	output logic             handler_req
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]                ctrl_mask;
		logic [`FPX_FLAG_W-1:0]    flags;
		logic                      fault_kind;
		logic [3:0]                cc;        // Condition bits three down to zero
		logic [2:0]                mainflags; // Zero, parity, carry
		logic                      dph_write;
		logic [3:0]                dph_addr;
		logic [31:0]               rdata;
		logic                      ready;
		fpx_resp_s                 resp;
		logic                      hreq;
	} fpx_state_s;

	fpx_state_s st_ff;
	fpx_state_s nxt_st;

	logic       imask;
	logic       dmask;
	logic       any_snan;
	logic       any_qnan;
	logic       any_unsup;
	logic       any_denorm;
	logic       ovf;
	logic       unf;
	logic       sfault;
	logic       bad_op;
	logic       den;
	logic       arith;
	logic [31:0] status_word;
	logic [31:0] rd_mux;

	assign imask = st_ff.ctrl_mask[`FPX_BIT_INVALID];
	assign dmask = st_ff.ctrl_mask[`FPX_BIT_SUBNORMAL];

	// ----------------------------------------------------------------
	// Register read view
	// ----------------------------------------------------------------
	// Summary is derived so it can never disagree with the flags
	always_comb begin
		status_word = 32'h0;
		status_word[`FPX_FLAG_W-1:0] = st_ff.flags;
		status_word[`FPX_BIT_SFKIND] = st_ff.fault_kind;
		status_word[`FPX_BIT_SUMMARY] = |st_ff.flags;
		status_word[`FPX_BIT_CND0] = st_ff.cc[0];
		status_word[`FPX_BIT_CND1] = st_ff.cc[1];
		status_word[`FPX_BIT_CND2] = st_ff.cc[2];
		status_word[`FPX_BIT_CND3] = st_ff.cc[3];
		case (haddr[3:0])
			`FPX_OFF_CTRL:      rd_mux = {30'h0, st_ff.ctrl_mask};
			`FPX_OFF_STATUS:    rd_mux = status_word;
			`FPX_OFF_MAINFLAGS: rd_mux = {29'h0, st_ff.mainflags};
			default:            rd_mux = 32'h0; // Unmapped reads as zero
		endcase
	end

	// ----------------------------------------------------------------
	// Operand classification
	// ----------------------------------------------------------------
	always_comb begin
		any_snan   = (req.a_used && req.a_cls == CLS_SNAN) ||
		             (req.b_used && req.b_cls == CLS_SNAN);
		any_qnan   = (req.a_used && req.a_cls == CLS_QNAN) ||
		             (req.b_used && req.b_cls == CLS_QNAN);
		any_unsup  = (req.a_used && req.a_cls == CLS_UNSUP) ||
		             (req.b_used && req.b_cls == CLS_UNSUP);
		any_denorm = (req.a_used && req.a_cls == CLS_DENORM) ||
		             (req.b_used && req.b_cls == CLS_DENORM);
		arith = !(req.op inside {OP_LOAD_MEM, OP_XCH, OP_OTHER});
		ovf = req.valid && req.op == OP_LOAD_MEM &&
		      req.dst_tag != `FPX_TAG_EMPTY;
		unf = req.valid && req.op != OP_XCH && req.op != OP_LOAD_MEM &&
		      ((req.a_used && req.a_tag == `FPX_TAG_EMPTY) ||
		       (req.b_used && req.b_tag == `FPX_TAG_EMPTY));
		sfault = ovf || unf;
		// Quiet NaNs pass silently unless the compare is ordered
		bad_op = arith && (any_snan || any_unsup);
		case (req.op)
			OP_ADD: bad_op = bad_op || (req.a_cls == CLS_INF && req.b_cls == CLS_INF &&
			             req.a_sign != req.b_sign);
			OP_SUB: bad_op = bad_op || (req.a_cls == CLS_INF && req.b_cls == CLS_INF &&
			             req.a_sign == req.b_sign);
			OP_MUL: bad_op = bad_op || (req.a_cls == CLS_INF && req.b_cls == CLS_ZERO) ||
			             (req.a_cls == CLS_ZERO && req.b_cls == CLS_INF);
			OP_DIV: bad_op = bad_op || (req.a_cls == CLS_INF && req.b_cls == CLS_INF) ||
			             (req.a_cls == CLS_ZERO && req.b_cls == CLS_ZERO);
			OP_PREM: bad_op = bad_op || req.b_cls == CLS_ZERO || req.a_cls == CLS_INF;
			OP_COS, OP_SIN, OP_SINCOS, OP_TAN: bad_op = bad_op || req.a_cls == CLS_INF;
			OP_SQRT, OP_YL2X: bad_op = bad_op || (req.a_sign && req.a_cls inside
			             {CLS_NORMAL, CLS_DENORM, CLS_INF});
			OP_YL2XP1: bad_op = bad_op || req.below_minus_one;
			OP_BCD_STORE_POP, OP_INT_STORE: bad_op = bad_op || !req.fits_range;
			OP_ORD_CMP, OP_CMP_FLAGS: bad_op = bad_op || any_qnan;
			OP_XCH: bad_op = req.a_tag == `FPX_TAG_EMPTY ||
			             req.b_tag == `FPX_TAG_EMPTY;
			default: bad_op = bad_op;
		endcase
		bad_op = bad_op && req.valid && !sfault;
		// Subnormal only when nothing invalid outranks it
		den = req.valid && !sfault && !bad_op &&
		      ((arith && any_denorm) ||
		       (req.op == OP_LOAD_MEM && req.a_cls == CLS_DENORM &&
		        req.load_fmt inside {FMT_SINGLE, FMT_DOUBLE}));
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.resp = '0;
		nxt_st.hreq = 1'b0;
		nxt_st.ready = 1'b1; // Zero wait states
		// Address phase capture; read data is ready for the data phase
		nxt_st.dph_write = 1'b0;
		if (hsel && hready && htrans[1]) begin
			nxt_st.dph_write = hwrite;
			nxt_st.dph_addr = haddr[3:0];
			if (!hwrite) begin
				nxt_st.rdata = rd_mux;
			end
		end
		// Data phase writes; hardware events below override them
		if (st_ff.dph_write) begin
			case (st_ff.dph_addr)
				`FPX_OFF_CTRL: nxt_st.ctrl_mask = hwdata[1:0];
				`FPX_OFF_STATUS: begin
					nxt_st.flags = hwdata[`FPX_FLAG_W-1:0];
					nxt_st.fault_kind = hwdata[`FPX_BIT_SFKIND];
					nxt_st.cc = {hwdata[`FPX_BIT_CND3], hwdata[`FPX_BIT_CND2],
					             hwdata[`FPX_BIT_CND1], hwdata[`FPX_BIT_CND0]};
				end
				`FPX_OFF_MAINFLAGS: nxt_st.mainflags = hwdata[2:0];
				default: nxt_st.mainflags = nxt_st.mainflags;
			endcase
		end
		// Exception response; set beats a same-cycle software clear
		if (req.valid) begin
			nxt_st.resp.valid = 1'b1;
			nxt_st.resp.stack_fault = sfault;
			nxt_st.resp.invalid = sfault || bad_op;
			nxt_st.resp.subnormal = den;
			if (sfault) begin
				nxt_st.flags[`FPX_BIT_INVALID] = 1'b1;
				nxt_st.fault_kind = 1'b1;
				nxt_st.cc[1] = ovf;
			end
			if (bad_op) begin
				nxt_st.flags[`FPX_BIT_INVALID] = 1'b1;
			end
			if (den) begin
				nxt_st.flags[`FPX_BIT_SUBNORMAL] = 1'b1;
			end
			if (((sfault || bad_op) && !imask) || (den && !dmask)) begin
				nxt_st.hreq = 1'b1;
			end else if (sfault) begin
				if (req.op == OP_BCD_STORE_POP) begin
					nxt_st.resp.subst = SUB_BCD_INDEF;
				end else if (req.op == OP_INT_STORE) begin
					nxt_st.resp.subst = SUB_INT_INDEF;
				end else begin
					nxt_st.resp.subst = SUB_QNAN_INDEF;
				end
			end else if (bad_op) begin
				case (req.op)
					OP_ORD_CMP, OP_UNORD_CMP: begin
						nxt_st.resp.cc_we = 1'b1;
						nxt_st.resp.cc_mask = 4'hD;
						nxt_st.resp.cc_val = 4'hD;
						nxt_st.cc[0] = 1'b1;
						nxt_st.cc[2] = 1'b1;
						nxt_st.cc[3] = 1'b1;
					end
					OP_CMP_FLAGS: begin
						nxt_st.resp.mf_we = 1'b1;
						nxt_st.resp.mf_val = `FPX_NAN_UNORDERED;
						nxt_st.mainflags = `FPX_NAN_UNORDERED;
					end
					OP_PREM, OP_COS, OP_SIN, OP_SINCOS, OP_TAN: begin
						nxt_st.resp.subst = SUB_QNAN_INDEF;
						nxt_st.resp.cc_we = 1'b1;
						nxt_st.resp.cc_mask = 4'h4;
						nxt_st.resp.cc_val = 4'h0;
						nxt_st.cc[2] = 1'b0;
					end
					OP_BCD_STORE_POP: nxt_st.resp.subst = SUB_BCD_INDEF;
					OP_INT_STORE: nxt_st.resp.subst = SUB_INT_INDEF;
					OP_XCH: begin
						nxt_st.resp.fill_a = req.a_tag == `FPX_TAG_EMPTY;
						nxt_st.resp.fill_b = req.b_tag == `FPX_TAG_EMPTY;
					end
					default: begin
						// Signalling NaN quiets unless an operand is unsupported or add/sub/mul/div has an infinite or zero first operand
						if (any_snan && !any_unsup && !(req.op inside
						    {OP_ADD, OP_SUB, OP_MUL, OP_DIV} &&
						    req.a_cls inside {CLS_INF, CLS_ZERO})) begin
							nxt_st.resp.subst = SUB_QUIET_SRC;
						end else begin
							nxt_st.resp.subst = SUB_QNAN_INDEF;
						end
					end
				endcase
			end else if (den && req.op == OP_LOAD_MEM) begin
				nxt_st.resp.normalize = 1'b1;
			end else if (req.a_cls == CLS_ZERO && req.a_sign) begin
				// Negative zero is legal for these two and has a fixed answer
				if (req.op == OP_SQRT) begin
					nxt_st.resp.subst = SUB_NEG_ZERO;
				end else if (req.op == OP_YL2X) begin
					nxt_st.resp.subst = SUB_NEG_INF;
				end
			end
			nxt_st.resp.commit = !nxt_st.hreq;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
			st_ff.ctrl_mask <= `FPX_CTRL_RST;
			st_ff.ready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state flops, except hresp, which is tied to OKAY
	assign hrdata = st_ff.rdata;
	assign hreadyout = st_ff.ready;
	assign hresp = `FPX_HRESP_OKAY;
	assign resp = st_ff.resp;
	assign handler_req = st_ff.hreq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_load_full;
		req.valid && req.op == OP_LOAD_MEM && req.dst_tag != `FPX_TAG_EMPTY;
	endsequence
	sequence s_fault_seen;
		resp.stack_fault && st_ff.flags[0] && st_ff.fault_kind;
	endsequence

	a_overflow_flags: assert property (s_load_full |=> s_fault_seen)
		else $error("overflow did not set invalid and stack-fault flags");
	a_c1_kind: assert property (req.valid && ovf |=> st_ff.cc[1] == 1'b1)
		else $error("overflow left condition bit one low");
	a_c1_under: assert property (req.valid && unf |=> !st_ff.cc[1])
		else $error("underflow left condition bit one high");
	a_sf_sticky: assert property (st_ff.fault_kind && !st_ff.dph_write |=> st_ff.fault_kind)
		else $error("stack-fault kind cleared without software write");
	a_handler_unmasked: assert property (req.valid && (sfault || bad_op) && !imask
		|=> handler_req && !resp.commit ##1 !handler_req)
		else $error("unmasked invalid did not give a one-cycle request");
	a_masked_subst: assert property (req.valid && sfault && imask
		|=> resp.subst != SUB_NONE && resp.commit && !handler_req)
		else $error("masked stack fault gave no indefinite");
	a_cmp_unordered: assert property (req.valid && req.op == OP_ORD_CMP && any_qnan &&
		!sfault && imask |=> st_ff.cc == 4'hD || st_ff.cc == 4'hF)
		else $error("masked NaN compare not unordered");
	a_qnan_silent: assert property (req.valid && req.op == OP_ADD && any_qnan &&
		!any_snan && !any_unsup && !sfault && req.a_cls != CLS_INF |=> !resp.invalid)
		else $error("quiet NaN raised invalid");
	a_ext_load_quiet: assert property (req.valid && req.op == OP_LOAD_MEM &&
		req.load_fmt == FMT_EXT && !sfault |=> !resp.subnormal)
		else $error("extended subnormal load flagged");
	a_subnormal_handler: assert property (den && !dmask |=> handler_req &&
		st_ff.flags[1])
		else $error("unmasked subnormal without request");
	a_summary_bit: assert property (st_ff.flags != '0 |-> status_word[7])
		else $error("summary bit low with a flag set");

	// ----------------------------------------------------------------
	// Masked answers
	// ----------------------------------------------------------------
	// Each masked case must leave its own mark, so a wrong decode shows
	a_operand_flag: assert property (bad_op |=> st_ff.flags[0])
		else $error("invalid operand left the invalid flag low");
	a_subnormal_flag: assert property (den |=> st_ff.flags[1])
		else $error("subnormal left its flag low");
	a_norm_load: assert property (den && req.op == OP_LOAD_MEM && dmask
		|=> resp.normalize && resp.commit)
		else $error("masked subnormal load not normalized");
	a_trig_cond2: assert property (bad_op && imask &&
		req.op inside {OP_PREM, OP_COS, OP_SIN, OP_SINCOS, OP_TAN}
		|=> !st_ff.cc[2] && resp.subst == SUB_QNAN_INDEF)
		else $error("remainder or trig fault kept condition bit two");
	a_xch_fill: assert property (bad_op && imask && req.op == OP_XCH &&
		req.a_tag == `FPX_TAG_EMPTY |=> resp.fill_a)
		else $error("exchange did not fill the empty register");
	a_flag_cmp: assert property (bad_op && imask && req.op == OP_CMP_FLAGS
		|=> resp.mf_we && st_ff.mainflags == `FPX_NAN_UNORDERED)
		else $error("masked flag compare not unordered");
	// Signalling NaN with a plain partner must keep its payload, quieted
	a_snan_quiet: assert property (bad_op && imask && req.op == OP_ADD &&
		req.a_cls == CLS_SNAN && req.b_cls == CLS_NORMAL
		|=> resp.subst == SUB_QUIET_SRC)
		else $error("signalling NaN not quieted");
	a_int_indef: assert property (bad_op && imask && req.op == OP_INT_STORE
		|=> resp.subst == SUB_INT_INDEF)
		else $error("integer store gave no integer indefinite");
	a_bcd_indef: assert property (bad_op && imask && req.op == OP_BCD_STORE_POP
		|=> resp.subst == SUB_BCD_INDEF)
		else $error("decimal store gave no decimal indefinite");

endmodule // fpx_exc_unit

// [testbench/fpx_dp_model.sv]
/*
 * Model of the arithmetic datapath and the sequencer beside the unit.
 * Assumes the bench hands it one request per cycle through go and cmd.
 */
`timescale 1ns/1ps
module fpx_dp_model
	import fpx_pkg::*;
(
	// Clock and reset
	input  wire logic      hclk,
	input  wire logic      hresetn,
	// Bench command
	input  wire logic      go,
	input  wire fpx_req_s  cmd,
	// Unit side
	output fpx_req_s       req,
	input  wire fpx_resp_s resp,
	input  wire logic      handler_req,
	output logic [7:0]     commit_cnt
);
	// Idle cycles show inverted fields so a stale request never passes
	always_comb begin
		if (go) begin
			req = cmd;
		end else begin
			req = fpx_req_s'({1'b0, ~cmd[$bits(fpx_req_s)-2:0]});
		end
	end

	// Results retire only when the unit lets the instruction commit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			commit_cnt <= 8'h00;
		end else if (resp.valid && resp.commit && !handler_req) begin
			commit_cnt <= commit_cnt + 8'h01;
		end
	end
endmodule // fpx_dp_model

// [testbench/testbench.sv]
/*
 * Self-checking bench of the exception unit: bus tasks and op sequences.
 * Assumes zero-wait bus answers and a response one cycle after a request.
 */
`timescale 1ns/1ps
`include "fpx_map.svh"
module testbench
	import fpx_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, handler_req, go;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  commit_cnt;
	logic [1:0]  side_exp;
	fpx_req_s    req, cmd, r;
	fpx_resp_s   resp;
	int          fails, checks_done;
	fpx_op_e     ops[5] = '{OP_COS, OP_SIN, OP_SINCOS, OP_TAN, OP_PREM};

	assign hready = hreadyout;

	fpx_exc_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req(req), .resp(resp),
		.handler_req(handler_req));
	fpx_dp_model dp_u (.hclk(hclk), .hresetn(hresetn), .go(go), .cmd(cmd), .req(req),
		.resp(resp), .handler_req(handler_req), .commit_cnt(commit_cnt));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic close_out();
		if (fails == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One single transfer; the master waits for hready on both phases
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
		chk("hresp", 32'(hresp), 32'(`FPX_HRESP_OKAY));
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk("rdata", rv & m, e);
	endtask

	// Issue r and check the one-cycle answer and the retire count
	task automatic run(input logic inv, stk, sub, input fpx_subst_e sb, input logic h);
		logic [7:0] c;
		c = commit_cnt;
		@(posedge hclk);
		go <= 1'b1; cmd <= r;
		@(posedge hclk);
		go <= 1'b0;
		#1;
		chk("resp.valid", 32'(resp.valid), 32'h1);
		chk("invalid", 32'(resp.invalid), 32'(inv));
		chk("stack_fault", 32'(resp.stack_fault), 32'(stk));
		chk("normalize_fill", 32'({resp.normalize, resp.fill_a}), 32'(side_exp));
		chk("subnormal", 32'(resp.subnormal), 32'(sub));
		chk("handler_req", 32'(handler_req), 32'(h));
		chk("commit", 32'(resp.commit), 32'(!h));
		if (!h) chk("subst", 32'(resp.subst), 32'(sb));
		@(posedge hclk);
		#1;
		chk("handler_req end", 32'(handler_req), 32'h0);
		chk("retired", 32'(commit_cnt), 32'(c + 8'(!h)));
	endtask

	task automatic base();
		r = '0;
		side_exp = 2'b00;
		r.valid = 1'b1; r.a_used = 1'b1; r.b_used = 1'b1;
		r.load_fmt = FMT_EXT; r.fits_range = 1'b1;
	endtask

	task automatic ex(input fpx_op_e o, input fpx_cls_e a, b, input logic s,
		input logic inv, input fpx_subst_e sb);
		base();
		r.op = o; r.a_cls = a; r.b_cls = b; r.a_sign = s;
		run(inv, 1'b0, 1'b0, sb, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog and sequence
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Whole run takes well under a thousand cycles
	initial begin
		#400000;
		fails++;
		close_out();
	end

	initial begin
		hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
		hsize = 3'h2; hwdata = '0; go = 1'b0; cmd = '0; r = '0;
		fails = 0; checks_done = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`FPX_OFF_CTRL, '1, 32'(`FPX_CTRL_RST));
		rd(`FPX_OFF_STATUS, '1, 32'h0);
		rd(`FPX_OFF_MAINFLAGS, '1, 32'h0);
		rd(32'hC, '1, 32'h0);
		// Overflow on every non-empty tag, none on empty
		for (int t = 0; t < 3; t++) begin
			base(); r.op = OP_LOAD_MEM; r.dst_tag = 2'(t); r.a_used = 0; r.b_used = 0;
			run(1, 1, 0, SUB_QNAN_INDEF, 0);
		end
		rd(`FPX_OFF_STATUS, '1, 32'h2C1);
		bus(1, `FPX_OFF_STATUS, 32'h0);
		r.dst_tag = `FPX_TAG_EMPTY;
		run(0, 0, 0, SUB_NONE, 0);
		// Underflow, with the indefinite form of each store
		base(); r.op = OP_STORE_MEM; r.a_tag = `FPX_TAG_EMPTY; r.b_used = 0;
		run(1, 1, 0, SUB_QNAN_INDEF, 0);
		rd(`FPX_OFF_STATUS, '1, 32'h0C1);
		r.op = OP_INT_STORE;
		run(1, 1, 0, SUB_INT_INDEF, 0);
		r.op = OP_BCD_STORE_POP;
		run(1, 1, 0, SUB_BCD_INDEF, 0);
		// Operand fault keeps an old stack-fault kind
		bus(1, `FPX_OFF_STATUS, 32'h40);
		ex(OP_ADD, CLS_INF, CLS_INF, 1, 1, SUB_QNAN_INDEF);
		rd(`FPX_OFF_STATUS, '1, 32'h0C1);
		ex(OP_SUB, CLS_INF, CLS_INF, 0, 1, SUB_QNAN_INDEF);
		ex(OP_MUL, CLS_INF, CLS_ZERO, 0, 1, SUB_QNAN_INDEF);
		ex(OP_MUL, CLS_ZERO, CLS_INF, 0, 1, SUB_QNAN_INDEF);
		ex(OP_DIV, CLS_INF, CLS_INF, 0, 1, SUB_QNAN_INDEF);
		ex(OP_DIV, CLS_ZERO, CLS_ZERO, 0, 1, SUB_QNAN_INDEF);
		ex(OP_ADD, CLS_UNSUP, CLS_NORMAL, 0, 1, SUB_QNAN_INDEF);
		ex(OP_ADD, CLS_SNAN, CLS_NORMAL, 0, 1, SUB_QUIET_SRC);
		ex(OP_SQRT, CLS_NORMAL, CLS_NORMAL, 1, 1, SUB_QNAN_INDEF);
		ex(OP_SQRT, CLS_ZERO, CLS_NORMAL, 1, 0, SUB_NEG_ZERO);
		base(); r.op = OP_YL2XP1; r.below_minus_one = 1;
		run(1, 0, 0, SUB_QNAN_INDEF, 0);
		base(); r.op = OP_BCD_STORE_POP; r.fits_range = 0;
		run(1, 0, 0, SUB_BCD_INDEF, 0);
		r.op = OP_INT_STORE;
		run(1, 0, 0, SUB_INT_INDEF, 0);
		base(); r.op = OP_XCH; r.a_tag = `FPX_TAG_EMPTY; side_exp = 2'b01;
		run(1, 0, 0, SUB_NONE, 0);
		// Remainder and trig faults clear condition bit two
		foreach (ops[i]) begin
			bus(1, `FPX_OFF_STATUS, 32'h400);
			ex(ops[i], CLS_INF, CLS_ZERO, 0, 1, SUB_QNAN_INDEF);
			rd(`FPX_OFF_STATUS, '1, 32'h081);
		end
		bus(1, `FPX_OFF_STATUS, 32'h0);
		ex(OP_ORD_CMP, CLS_QNAN, CLS_NORMAL, 0, 1, SUB_NONE);
		rd(`FPX_OFF_STATUS, '1, 32'h4581);
		ex(OP_CMP_FLAGS, CLS_QNAN, CLS_NORMAL, 0, 1, SUB_NONE);
		rd(`FPX_OFF_MAINFLAGS, '1, 32'h7);
		// Subnormal loads, masked
		bus(1, `FPX_OFF_STATUS, 32'h0);
		base(); r.op = OP_LOAD_MEM; r.dst_tag = `FPX_TAG_EMPTY; r.a_cls = CLS_DENORM;
		r.load_fmt = FMT_SINGLE; side_exp = 2'b10;
		run(0, 0, 1, SUB_NONE, 0);
		rd(`FPX_OFF_STATUS, '1, 32'h082);
		r.load_fmt = FMT_DOUBLE;
		run(0, 0, 1, SUB_NONE, 0);
		r.load_fmt = FMT_EXT; side_exp = 2'b00;
		run(0, 0, 0, SUB_NONE, 0);
		// Unmasked: handler requests; only the quiet-NaN add retires
		bus(1, `FPX_OFF_CTRL, 32'h0);
		rd(`FPX_OFF_CTRL, '1, 32'h0);
		bus(1, `FPX_OFF_STATUS, 32'h0);
		ex(OP_ADD, CLS_QNAN, CLS_NORMAL, 0, 0, SUB_NONE);
		base(); r.op = OP_ORD_CMP; r.a_cls = CLS_QNAN;
		run(1, 0, 0, SUB_NONE, 1);
		base(); r.op = OP_LOAD_MEM; r.a_used = 0; r.b_used = 0;
		run(1, 1, 0, SUB_NONE, 1);
		base(); r.op = OP_ADD; r.b_cls = CLS_DENORM;
		run(0, 0, 1, SUB_NONE, 1);
		rd(`FPX_OFF_STATUS, 32'hC3, 32'hC3);
		close_out();
	end
endmodule // testbench
